// ==== hdl/pfc_defs.vh ====
// constants and register map of the pin function controller
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// ==========================================================
// register byte offsets
`define PFC_PIN_SEL_OFS 8'h00
`define PFC_FUNC_OFS 8'h04
`define PFC_SUBFUNC_OFS 8'h08
`define PFC_CFG_GO_OFS 8'h0C
`define PFC_RESULT_OFS 8'h10
`define PFC_WRITE_OFS 8'h14
`define PFC_READ_OFS 8'h18
`define PFC_PWM_PERIOD_OFS 8'h1C
`define PFC_PWM_FREQ_OFS 8'h20
`define PFC_PWM_GO_OFS 8'h24

// ==========================================================
// field positions and codes
`define PFC_NPIN 8
`define PFC_FN_DIG_IN 2'h1
`define PFC_FN_DIG_OUT 2'h2
`define PFC_FN_ANALOG 2'h3
`define PFC_SUB_GAIN_LSB 0
`define PFC_SUB_RES_LSB 8
`define PFC_SUB_ACQ_LSB 16
`define PFC_SUB_DRV_LSB 4
`define PFC_DEF_GAIN 8'h16
`define PFC_DEF_RES 8'h0A
`define PFC_DEF_ACQ 8'h0A
`define PFC_FREQ_MAX 32'h003D0900
`define PFC_PWM_HZ 32'h000F4240

// result codes
`define PFC_RC_OK 16'h0000
`define PFC_RC_BAD_PIN 16'h0001
`define PFC_RC_BAD_FUNC 16'h0002
`define PFC_RC_BAD_CODE 16'h0003
`define PFC_RC_PWM_FAIL 16'h0004

// ==========================================================
// timing
`define PFC_HCLK_HZ 40000000
`define PFC_TICK_NS 1000
`define PFC_HCLK_NS 25
`define PFC_TICK_CYC (`PFC_TICK_NS / `PFC_HCLK_NS)

// reset values
`define PFC_PERIOD_RST 32'h000003E8
`define PFC_RC_RST 16'h0000

`endif

// ==== hdl/pfc_pin_ctrl.v ====
// ahb-lite pin function controller: output, pwm, frequency, analog
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pfc_defs.vh"

module pfc_pin_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe,
  output wire [7:0] pin_hd,
  input wire [11:0] adc_data,
  output reg [2:0] adc_pin,
  output reg adc_en,
  output reg [7:0] adc_gain,
  output reg [7:0] adc_res,
  output reg [7:0] adc_acq
);

  // ==========================================================
  // decode functions
  // drive code to {high disconnect, high strong, low disc, low strong}
  function [3:0] drv_dec;
    input [2:0] code;
    begin
      case (code)
        3'd0: drv_dec = 4'h0;
        3'd1: drv_dec = 4'h1;
        3'd2: drv_dec = 4'h4;
        3'd3: drv_dec = 4'h5;
        3'd4: drv_dec = 4'h2;
        3'd5: drv_dec = 4'h6;
        3'd6: drv_dec = 4'h8;
        default: drv_dec = 4'h9;
      endcase
    end
  endfunction

  function gain_ok;
    input [7:0] c;
    begin
      gain_ok = (c == 8'h00) || (c >= 8'h11 && c <= 8'h16) ||
                (c == 8'h21) || (c == 8'h41);
    end
  endfunction

  function res_ok;
    input [7:0] c;
    begin
      res_ok = (c == 8'h00) || (c == 8'h08) || (c == 8'h0A) ||
               (c == 8'h0C);
    end
  endfunction

  function acq_ok;
    input [7:0] c;
    begin
      acq_ok = (c == 8'h00) || (c == 8'h03) || (c == 8'h05) ||
               (c == 8'h0A) || (c == 8'h0F) || (c == 8'h14) ||
               (c == 8'h28);
    end
  endfunction

  // pin modes
  localparam [2:0] M_IN = 3'd0;
  localparam [2:0] M_OUT = 3'd1;
  localparam [2:0] M_PWM = 3'd2;
  localparam [2:0] M_FREQ = 3'd3;
  localparam [2:0] M_ANA = 3'd4;

  // bus phases
  localparam [1:0] P_IDLE = 2'd0;
  localparam [1:0] P_WAIT = 2'd1;
  localparam [1:0] P_DONE = 2'd2;

  // ==========================================================
  // ahb-lite slave: one wait state per data phase
  reg [1:0] phase_q;
  reg [7:0] addr_q;
  reg write_q;
  wire take = hsel && hready && htrans[1];

  assign hreadyout = (phase_q != P_WAIT);
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= P_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
    end else begin
      case (phase_q)
        P_WAIT: phase_q <= P_DONE;
        default: phase_q <= take ? P_WAIT : P_IDLE;
      endcase
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
        write_q <= hwrite;
      end
    end
  end

  // write strobes land on the edge ending the wait cycle
  wire wr = (phase_q == P_WAIT) && write_q;
  wire rd = (phase_q == P_WAIT) && !write_q;
  wire wr_cfg_go = wr && (addr_q == `PFC_CFG_GO_OFS);
  wire wr_pin_val = wr && (addr_q == `PFC_WRITE_OFS);
  wire wr_pwm_go = wr && (addr_q == `PFC_PWM_GO_OFS);

  // ==========================================================
  // software registers
  reg [7:0] pin_sel_q;
  reg [1:0] func_q;
  reg [31:0] sub_q;
  reg [15:0] rc_q;
  reg [31:0] period_q;
  reg [31:0] freq_q;

  wire sel_ok = (pin_sel_q < `PFC_NPIN);
  wire [7:0] sub_gain = sub_q[`PFC_SUB_GAIN_LSB +: 8];
  wire [7:0] sub_res = sub_q[`PFC_SUB_RES_LSB +: 8];
  wire [7:0] sub_acq = sub_q[`PFC_SUB_ACQ_LSB +: 8];
  wire out_code_ok = (sub_q[3:0] <= 4'd3) && (sub_q[31:7] == 25'd0);

  // result of a configuration request, checked before anything moves
  reg [15:0] cfg_rc;
  always @* begin
    cfg_rc = `PFC_RC_OK;
    if (!sel_ok)
      cfg_rc = `PFC_RC_BAD_PIN;
    else if (func_q == 2'd0)
      cfg_rc = `PFC_RC_BAD_FUNC;
    else if (func_q == `PFC_FN_DIG_OUT && !out_code_ok)
      cfg_rc = `PFC_RC_BAD_CODE;
    else if (func_q == `PFC_FN_ANALOG && !(gain_ok(sub_gain) &&
             res_ok(sub_res) && acq_ok(sub_acq)))
      cfg_rc = `PFC_RC_BAD_CODE;
  end
  wire cfg_apply = wr_cfg_go && (cfg_rc == `PFC_RC_OK);

  // achievable pwm frequency; divider kept combinational for simplicity
  wire [31:0] pwm_req = hwdata;
  wire [31:0] pwm_ach = (period_q == 32'd0) ? 32'd0 :
                        (`PFC_PWM_HZ / period_q);
  wire pwm_fail = (period_q == 32'd0) || (freq_q > pwm_ach);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sel_q <= 8'h00;
      func_q <= 2'h0;
      sub_q <= 32'h00000000;
      rc_q <= `PFC_RC_RST;
      period_q <= `PFC_PERIOD_RST;
      freq_q <= 32'h00000000;
    end else begin
      if (wr && addr_q == `PFC_PIN_SEL_OFS)
        pin_sel_q <= hwdata[7:0];
      if (wr && addr_q == `PFC_FUNC_OFS)
        func_q <= hwdata[1:0];
      if (wr && addr_q == `PFC_SUBFUNC_OFS)
        sub_q <= hwdata;
      if (wr && addr_q == `PFC_PWM_PERIOD_OFS)
        period_q <= hwdata;
      if (wr && addr_q == `PFC_PWM_FREQ_OFS)
        freq_q <= pwm_req;
      if (wr_cfg_go)
        rc_q <= cfg_rc;
      if (wr_pwm_go) begin
        rc_q <= pwm_fail ? `PFC_RC_PWM_FAIL : `PFC_RC_OK;
        if (!pwm_fail)
          freq_q <= pwm_ach;
      end
    end
  end

  // ==========================================================
  // pin input synchronisers
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ==========================================================
  // 1 MHz tick shared by all pwm timers
  reg [7:0] div_q;
  wire tick = (div_q == `PFC_TICK_CYC - 1);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      div_q <= 8'h00;
    else
      div_q <= tick ? 8'h00 : div_q + 8'd1;
  end

  // ==========================================================
  // per-pin state and waveform generation
  wire [3*`PFC_NPIN-1:0] mode_w;
  wire [32*`PFC_NPIN-1:0] val_w;
  wire [24*`PFC_NPIN-1:0] ana_w;

  genvar g;
  generate
    for (g = 0; g < `PFC_NPIN; g = g + 1) begin : pin
      reg [2:0] mode_q;
      reg lvl_q;
      reg [2:0] drv_q;
      reg [31:0] val_q;
      reg [7:0] gain_q;
      reg [7:0] res_q;
      reg [7:0] acq_q;
      reg [31:0] cnt_q;
      reg [26:0] acc_q;
      reg sq_q;
      reg o_q;
      reg oe_q;
      reg hd_q;
      reg o_d;
      reg [3:0] dv;
      wire hit = (pin_sel_q == g);
      wire [27:0] acc_sum = {1'b0, acc_q} + {val_q[26:0], 1'b0};

      // configuration and value writes
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mode_q <= M_IN;
          lvl_q <= 1'b0;
          drv_q <= 3'd0;
          val_q <= 32'h00000000;
          gain_q <= `PFC_DEF_GAIN;
          res_q <= `PFC_DEF_RES;
          acq_q <= `PFC_DEF_ACQ;
        end else if (cfg_apply && hit) begin
          val_q <= 32'h00000000;
          case (func_q)
            `PFC_FN_DIG_OUT: begin
              case (sub_q[1:0])
                2'd0: mode_q <= M_OUT;
                2'd1: mode_q <= M_OUT;
                2'd2: mode_q <= M_PWM;
                default: mode_q <= M_FREQ;
              endcase
              lvl_q <= (sub_q[1:0] == 2'd1);
              drv_q <= sub_q[`PFC_SUB_DRV_LSB +: 3];
            end
            `PFC_FN_ANALOG: begin
              mode_q <= M_ANA;
              // zero field, or no fields at all, takes the default
              gain_q <= (sub_gain == 8'h00) ? `PFC_DEF_GAIN : sub_gain;
              res_q <= (sub_res == 8'h00) ? `PFC_DEF_RES : sub_res;
              acq_q <= (sub_acq == 8'h00) ? `PFC_DEF_ACQ : sub_acq;
            end
            default: mode_q <= M_IN;
          endcase
        end else if (wr_pin_val && hit) begin
          lvl_q <= (hwdata != 32'd0);
          if (mode_q == M_PWM)
            val_q <= (hwdata > period_q) ? period_q : hwdata;
          else if (mode_q == M_FREQ)
            val_q <= (hwdata > `PFC_FREQ_MAX) ? `PFC_FREQ_MAX : hwdata;
          else
            val_q <= hwdata;
        end
      end

      // pwm counter wraps at the global period, even if shrunk
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          cnt_q <= 32'h00000000;
        else if (mode_q != M_PWM)
          cnt_q <= 32'h00000000;
        else if (tick)
          cnt_q <= (cnt_q + 32'd1 >= period_q) ? 32'd0 :
                   cnt_q + 32'd1;
      end

      // square wave by phase accumulator, toggling at twice the rate
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          acc_q <= 27'd0;
          sq_q <= 1'b0;
        end else if (mode_q != M_FREQ || val_q == 32'd0) begin
          acc_q <= 27'd0;
          sq_q <= 1'b0;
        end else if (acc_sum >= `PFC_HCLK_HZ) begin
          acc_q <= acc_sum[26:0] - 27'd40000000;
          sq_q <= ~sq_q;
        end else begin
          acc_q <= acc_sum[26:0];
        end
      end

      // level and drive per mode
      always @* begin
        o_d = 1'b0;
        dv = 4'h0;
        case (mode_q)
          M_OUT: begin
            o_d = lvl_q;
            dv = drv_dec(drv_q);
          end
          M_PWM: o_d = (cnt_q < val_q);
          M_FREQ: o_d = sq_q;
          default: o_d = 1'b0;
        endcase
      end

      // outputs registered; pwm and frequency modes keep standard drive
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          o_q <= 1'b0;
          oe_q <= 1'b0;
          hd_q <= 1'b0;
        end else begin
          o_q <= o_d;
          oe_q <= (mode_q == M_OUT || mode_q == M_PWM ||
                   mode_q == M_FREQ) &&
                  !(o_d ? dv[3] : dv[1]);
          hd_q <= o_d ? dv[2] : dv[0];
        end
      end

      assign pin_o[g] = o_q;
      assign pin_oe[g] = oe_q;
      assign pin_hd[g] = hd_q;
      assign mode_w[3*g +: 3] = mode_q;
      assign val_w[32*g +: 32] = val_q;
      assign ana_w[24*g +: 24] = {acq_q, res_q, gain_q};
    end
  endgenerate

  // ==========================================================
  // selected pin view and converter steering
  wire [2:0] sel_idx = pin_sel_q[2:0];
  wire [2:0] sel_mode = mode_w[3*sel_idx +: 3];
  wire [23:0] sel_ana = ana_w[24*sel_idx +: 24];
  wire [31:0] sel_val = val_w[32*sel_idx +: 32];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_pin <= 3'd0;
      adc_en <= 1'b0;
      adc_gain <= `PFC_DEF_GAIN;
      adc_res <= `PFC_DEF_RES;
      adc_acq <= `PFC_DEF_ACQ;
    end else begin
      adc_pin <= sel_idx;
      adc_en <= sel_ok && (sel_mode == M_ANA);
      adc_gain <= sel_ana[7:0];
      adc_res <= sel_ana[15:8];
      adc_acq <= sel_ana[23:16];
    end
  end

  // pin read value: level, scaled conversion, or zero
  reg [31:0] pin_rd;
  always @* begin
    pin_rd = 32'h00000000;
    if (!sel_ok)
      pin_rd = 32'h00000000;
    else if (sel_mode == M_ANA) begin
      case (sel_ana[15:8])
        8'h08: pin_rd = {24'h000000, adc_data[11:4]};
        8'h0C: pin_rd = {20'h00000, adc_data};
        default: pin_rd = {22'h000000, adc_data[11:2]};
      endcase
    end else
      pin_rd = {31'h00000000, pin_s2_q[sel_idx]};
  end

  // ==========================================================
  // read data captured at the end of the wait cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd) begin
      case (addr_q)
        `PFC_PIN_SEL_OFS: hrdata <= {24'h000000, pin_sel_q};
        `PFC_FUNC_OFS: hrdata <= {30'h00000000, func_q};
        `PFC_SUBFUNC_OFS: hrdata <= sub_q;
        `PFC_RESULT_OFS: hrdata <= {16'h0000, rc_q};
        `PFC_WRITE_OFS: hrdata <= sel_ok ? sel_val : 32'h00000000;
        `PFC_READ_OFS: hrdata <= pin_rd;
        `PFC_PWM_PERIOD_OFS: hrdata <= period_q;
        `PFC_PWM_FREQ_OFS: hrdata <= freq_q;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // pfc_pin_ctrl

// ==== dv/pfc_pin_model.sv ====
// pin wiring and converter model on the far side of the pin controller
`timescale 1ns/1ps
module pfc_pin_model (
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_lvl,
  input wire adc_en,
  input wire [11:0] adc_val,
  output wire [7:0] pin_i,
  output wire [11:0] adc_data
);
  // driven pins read back their own level, released pins the outside one
  assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
  // unselected converter shows the inverse, so stale data cannot match
  assign adc_data = adc_en ? adc_val : ~adc_val;
endmodule // pfc_pin_model

// ==== dv/pfc_pin_ctrl_sva.sv ====
// port assertions for the pin function controller
`timescale 1ns/1ps
`include "pfc_defs.vh"
module pfc_pin_ctrl_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [7:0] pin_oe,
  input wire adc_en,
  input wire [7:0] adc_gain,
  input wire [7:0] adc_res,
  input wire [7:0] adc_acq
);
  wire acc = hsel && hready && htrans[1];
  reg rd_q;
  // marks the data phase of a level read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_q <= 1'b0;
    else if (hready) rd_q <= acc && !hwrite && haddr[7:0] == `PFC_READ_OFS;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // bus and reset
  property p_wait;
    acc |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_resp;
    hresp == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_rst;
    $rose(hresetn) |-> pin_oe == 8'h00 && !adc_en && adc_gain == 8'h16
      && adc_res == 8'h0A && adc_acq == 8'h0A;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  // ==========
  // converter codes and reads
  property p_gain;
    adc_gain inside {[8'h11:8'h16], 8'h21, 8'h41};
  endproperty
  a_gain: assert property (p_gain) else $error("bad gain");
  property p_res;
    adc_res inside {8'h08, 8'h0A, 8'h0C};
  endproperty
  a_res: assert property (p_res) else $error("bad resolution");
  property p_acq;
    adc_acq inside {8'h03, 8'h05, 8'h0A, 8'h0F, 8'h14, 8'h28};
  endproperty
  a_acq: assert property (p_acq) else $error("bad acquisition");
  property p_rd_dig;
    rd_q && hreadyout && !adc_en |-> hrdata[31:1] == 31'h0;
  endproperty
  a_rd_dig: assert property (p_rd_dig) else $error("digital read");
  property p_rd_ana;
    rd_q && hreadyout && adc_en |-> hrdata[31:12] == 20'h0;
  endproperty
  a_rd_ana: assert property (p_rd_ana) else $error("analog read");
endmodule // pfc_pin_ctrl_sva

bind pfc_pin_ctrl pfc_pin_ctrl_sva pfc_pin_ctrl_sva_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pin_oe(pin_oe), .adc_en(adc_en), .adc_gain(adc_gain),
  .adc_res(adc_res), .adc_acq(adc_acq));

// ==== dv/pfc_pin_ctrl_test.sv ====
// self-checking bench for the pin function controller
`timescale 1ns/1ps
`include "pfc_defs.vh"
module pfc_pin_ctrl_test;
  reg hclk, hresetn, hsel, hwrite;
  reg [31:0] haddr, hwdata;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [7:0] ext_lvl;
  reg [11:0] adc_val;
  wire hready, hreadyout, hresp, adc_en;
  wire [31:0] hrdata;
  wire [7:0] pin_i, pin_o, pin_oe, pin_hd, adc_gain, adc_res, adc_acq;
  wire [11:0] adc_data;
  wire [2:0] adc_pin;
  logic [31:0] exp_q[$];
  logic [31:0] e_m, wv, r;
  logic mon_rd = 1'b0;
  logic lv, eo, hd_e;
  logic [2:0] code, p;
  logic [7:0] g, rs, aq;
  int n_mismatch = 0, n_tests = 0, cyc = 0, k, hi, tg;
  logic [7:0] gt[9] = '{8'h00, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11,
    8'h21, 8'h41};
  logic [7:0] rt[4] = '{8'h00, 8'h08, 8'h0A, 8'h0C};
  logic [7:0] at[7] = '{8'h00, 8'h03, 8'h05, 8'h0A, 8'h0F, 8'h14, 8'h28};
  logic [31:0] dt[4] = '{32'h0, 32'h3, 32'h8, 32'hC};
  logic [31:0] ft[3] = '{32'h0, `PFC_PWM_HZ, `PFC_FREQ_MAX};
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  pfc_pin_ctrl pfc_pin_ctrl_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_hd(pin_hd),
    .adc_data(adc_data), .adc_pin(adc_pin), .adc_en(adc_en),
    .adc_gain(adc_gain), .adc_res(adc_res), .adc_acq(adc_acq));
  pfc_pin_model pfc_pin_model_inst (.pin_o(pin_o), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .adc_en(adc_en), .adc_val(adc_val),
    .pin_i(pin_i), .adc_data(adc_data));
  // ==========
  // clock, watchdog and shared tasks
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // a hung handshake ends the run as a mismatch
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task ahb_xfer(input [7:0] a, input w, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task ahb_chk(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    ahb_xfer(a, 1'b0, 32'h0);
  endtask
  task rc_chk(input [31:0] e);
    ahb_chk(`PFC_RESULT_OFS, e);
  endtask
  task cfg(input [7:0] pn, input [1:0] f, input [31:0] s);
    ahb_xfer(`PFC_PIN_SEL_OFS, 1'b1, {24'h0, pn});
    ahb_xfer(`PFC_FUNC_OFS, 1'b1, {30'h0, f});
    ahb_xfer(`PFC_SUBFUNC_OFS, 1'b1, s);
    ahb_xfer(`PFC_CFG_GO_OFS, 1'b1, 32'h1);
  endtask
  // counts high cycles and level changes of one pin
  task measure(input [2:0] pn, input int n, output int h, output int t);
    logic last;
    last = pin_o[pn];
    h = 0;
    t = 0;
    repeat (n) begin
      @(posedge hclk);
      h += pin_o[pn];
      t += pin_o[pn] !== last;
      last = pin_o[pn];
    end
  endtask
  // read monitor: oldest note is compared when a read data phase ends
  always @(posedge hclk) begin
    if (mon_rd && hreadyout) begin
      e_m = exp_q.pop_front();
      check(hrdata, e_m);
    end
    if (hreadyout) mon_rd = hsel && htrans[1] && !hwrite;
  end
  // ==========
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_lvl = 8'h00;
    adc_val = 12'h000;
    r = $urandom(32'hE4EB);
    ext_lvl = 8'($urandom);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb_xfer(`PFC_PIN_SEL_OFS, 1'b1, 32'h0);
    rc_chk(`PFC_RC_RST);
    ahb_chk(`PFC_PWM_PERIOD_OFS, `PFC_PERIOD_RST);
    ahb_xfer(8'h3C, 1'b1, $urandom);
    ahb_chk(8'h3C, 32'h0);
    ahb_chk(`PFC_READ_OFS, {31'h0, ext_lvl[0]});
    check(pin_oe, 8'h00);
    $display("reset test done");
    // every drive code at both start levels, then a write of the other
    for (k = 0; k < 16; k++) begin
      p = 3'($urandom);
      code = 3'(k >> 1);
      lv = k[0];
      cfg({5'h0, p}, 2'h2, {25'h0, code, 3'h0, lv});
      rc_chk(`PFC_RC_OK);
      repeat (2) @(posedge hclk);
      check(pin_o[p], lv);
      eo = lv ? code < 6 : code != 4 && code != 5;
      hd_e = lv ? code == 2 || code == 3 || code == 5 : code[0] && code != 5;
      check(pin_oe[p], eo);
      if (eo) check(pin_hd[p], hd_e);
      wv = lv ? 32'h0 : $urandom | 32'h1;
      ahb_xfer(`PFC_WRITE_OFS, 1'b1, wv);
      repeat (4) @(posedge hclk);
      check(pin_o[p], !lv);
      eo = lv ? code != 4 && code != 5 : code < 6;
      ahb_chk(`PFC_READ_OFS, eo ? !lv : ext_lvl[p]);
    end
    for (k = 0; k < 3; k++) begin
      cfg({5'h0, p}, k == 2 ? 2'h0 : 2'h2, k == 0 ? 32'h4 : 32'h80);
      rc_chk(k == 2 ? `PFC_RC_BAD_FUNC : `PFC_RC_BAD_CODE);
      // last pin holds code 7 at low level: driven, strong low drive
      check({pin_o[p], pin_oe[p], pin_hd[p]}, 3'b011);
    end
    // back to input: the pin releases and reads the outside level
    cfg({5'h0, p}, 2'h1, 32'h0);
    rc_chk(`PFC_RC_OK);
    ahb_chk(`PFC_READ_OFS, {31'h0, ext_lvl[p]});
    $display("digital output test done");
    // every gain, resolution and acquisition code
    for (k = 0; k < 9; k++) begin
      p = 3'($urandom);
      g = gt[k];
      rs = rt[k % 4];
      aq = at[k % 7];
      cfg({5'h0, p}, 2'h3, {8'h0, aq, rs, g});
      rc_chk(`PFC_RC_OK);
      adc_val <= 12'($urandom);
      repeat (3) @(posedge hclk);
      g = g == 8'h00 ? 8'h16 : g;
      rs = rs == 8'h00 ? 8'h0A : rs;
      aq = aq == 8'h00 ? 8'h0A : aq;
      check({adc_en, adc_pin}, {1'b1, p});
      check({adc_gain, adc_res, adc_acq}, {g, rs, aq});
      wv = rs == 8'h08 ? adc_val[11:4] : rs == 8'h0C ? adc_val : adc_val[11:2];
      ahb_chk(`PFC_READ_OFS, wv);
    end
    for (k = 0; k < 3; k++) begin
      cfg({5'h0, p}, 2'h3, 32'h000A0A16 | (32'h1 << (8 * k)));
      rc_chk(`PFC_RC_BAD_CODE);
      check({adc_gain, adc_res, adc_acq}, {g, rs, aq});
    end
    cfg({5'h0, p}, 2'h3, 32'h0);
    rc_chk(`PFC_RC_OK);
    repeat (2) @(posedge hclk);
    check({adc_gain, adc_res, adc_acq}, 24'h160A0A);
    cfg(8'h09, 2'h2, 32'h1);
    rc_chk(`PFC_RC_BAD_PIN);
    ahb_chk(`PFC_READ_OFS, 32'h0);
    $display("analog test done");
    // global period, achieved frequency, duty levels
    ahb_xfer(`PFC_PWM_PERIOD_OFS, 1'b1, 32'h8);
    ahb_xfer(`PFC_PWM_FREQ_OFS, 1'b1, 32'h000186A0);
    ahb_xfer(`PFC_PWM_GO_OFS, 1'b1, 32'h1);
    rc_chk(`PFC_RC_OK);
    ahb_chk(`PFC_PWM_FREQ_OFS, `PFC_PWM_HZ / 8);
    ahb_xfer(`PFC_PWM_FREQ_OFS, 1'b1, `PFC_PWM_HZ / 8 + 1);
    ahb_xfer(`PFC_PWM_GO_OFS, 1'b1, 32'h1);
    rc_chk(`PFC_RC_PWM_FAIL);
    p = 3'($urandom);
    cfg({5'h0, p}, 2'h2, 32'h32);
    rc_chk(`PFC_RC_OK);
    for (k = 0; k < 4; k++) begin
      ahb_xfer(`PFC_WRITE_OFS, 1'b1, dt[k]);
      ahb_chk(`PFC_WRITE_OFS, dt[k] > 8 ? 32'h8 : dt[k]);
      repeat (400) @(posedge hclk);
      measure(p, 640, hi, tg);
      check(hi, (dt[k] > 8 ? 8 : dt[k]) * 80);
      check(pin_hd[p], 1'b0);
    end
    ahb_xfer(`PFC_PWM_PERIOD_OFS, 1'b1, 32'h10);
    ahb_xfer(`PFC_WRITE_OFS, 1'b1, 32'h3);
    repeat (700) @(posedge hclk);
    measure(p, 1280, hi, tg);
    check(hi, 240);
    wv = $urandom;
    ahb_xfer(`PFC_PWM_PERIOD_OFS, 1'b1, wv);
    ahb_chk(`PFC_PWM_PERIOD_OFS, wv);
    $display("pwm test done");
    // square wave off, at 1 MHz and at the top rate
    p = 3'($urandom);
    cfg({5'h0, p}, 2'h2, 32'h33);
    rc_chk(`PFC_RC_OK);
    for (k = 0; k < 3; k++) begin
      wv = ft[k];
      ahb_xfer(`PFC_WRITE_OFS, 1'b1, wv);
      repeat (100) @(posedge hclk);
      measure(p, 400, hi, tg);
      // whole periods fit the window, so both counts are exact
      check(hi, k > 0 ? 200 : 0);
      check(tg, wv / 32'h0000C350);
      check(pin_hd[p], 1'b0);
    end
    $display("frequency test done");
    finish_test;
  end
endmodule // pfc_pin_ctrl_test
